// ===== src/fps_sequencer.sv
// Flash pulse sequencer: drives array mode controls with timed pulses and verify loop
module fps_sequencer
	import fps_pkg::*;
#(
	parameter int STAB_CYCLES  = STAB_CYC,
	parameter int PGM_CYCLES   = PGM_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int FLW_CYCLES   = FLW_CYC
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// Command
	input  wire logic        start,
	input  wire fps_op_t     op,
	// Array interface
	input  wire logic        verify_ok,
	output fps_mode_t        mode_r,
	// Status
	output logic             busy_r,
	output logic             done_r,
	output fps_result_t      result_r
);

	// ------------------------------------------------------------
	// Reset release and pin synchroniser
	// ------------------------------------------------------------
	logic rst_s1_r;
	logic rst_n_r;
	logic vok_s1_r;
	logic vok_r;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			vok_s1_r <= 1'b0;
			vok_r    <= 1'b0;
		end else begin
			vok_s1_r <= verify_ok;
			vok_r    <= vok_s1_r;
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_SETUP  = 3'h1,
		ST_PULSE  = 3'h2,
		ST_DESEL  = 3'h3,
		ST_VSETUP = 3'h4,
		ST_VCHECK = 3'h5,
		ST_EXIT   = 3'h6
	} fps_state_t;

	fps_state_t        state_r;
	fps_state_t        state_nxt;
	fps_op_t           op_r;
	logic [CNT_W-1:0]  tmr_r;
	logic [CNT_W-1:0]  tmr_nxt;
	logic [PCNT_W-1:0] pcnt_r;
	logic [CNT_W-1:0]  pulse_len;
	logic [PCNT_W-1:0] pulse_max;
	logic              tmr_done;
	logic              pass_nxt;
	logic              fail_nxt;
	fps_op_t           op_sel;

	always_comb begin
		case (op_r)
			FPS_OP_ERASE: begin
				pulse_len = CNT_W'(ERASE_CYCLES);
				pulse_max = PCNT_W'(ERASE_MAX_PULSES);
			end
			FPS_OP_FLW: begin
				pulse_len = CNT_W'(FLW_CYCLES);
				pulse_max = PCNT_W'(FLW_MAX_PULSES);
			end
			default: begin
				pulse_len = CNT_W'(PGM_CYCLES);
				pulse_max = PCNT_W'(PGM_MAX_PULSES);
			end
		endcase
	end

	assign tmr_done = (tmr_r == '0);

	// New op must steer the select from its first cycle, not a cycle late
	assign op_sel = (state_r == ST_IDLE && start) ? op : op_r;

	always_comb begin
		state_nxt = state_r;
		tmr_nxt   = (tmr_r == '0) ? tmr_r : tmr_r - CNT_W'(1);
		pass_nxt  = 1'b0;
		fail_nxt  = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (start) begin
					state_nxt = ST_SETUP;
					tmr_nxt   = CNT_W'(STAB_CYCLES - 1);
				end
			end
			ST_SETUP: begin
				if (tmr_done) begin
					state_nxt = ST_PULSE;
					tmr_nxt   = pulse_len - CNT_W'(1);
				end
			end
			ST_PULSE: begin
				if (tmr_done) begin
					state_nxt = ST_DESEL;
					tmr_nxt   = CNT_W'(STAB_CYCLES - 1);
				end
			end
			ST_DESEL: begin
				if (tmr_done) begin
					state_nxt = ST_VSETUP;
					// One cycle more: first sync flop catches the pin after the full wait
					tmr_nxt   = CNT_W'(STAB_CYCLES);
				end
			end
			ST_VSETUP: begin
				if (tmr_done) begin
					state_nxt = ST_VCHECK;
				end
			end
			ST_VCHECK: begin
				if (vok_r) begin
					pass_nxt  = 1'b1;
					state_nxt = ST_EXIT;
					tmr_nxt   = CNT_W'(STAB_CYCLES - 1);
				end else if (pcnt_r >= pulse_max) begin
					fail_nxt  = 1'b1;
					state_nxt = ST_EXIT;
					tmr_nxt   = CNT_W'(STAB_CYCLES - 1);
				end else begin
					state_nxt = ST_SETUP;
					tmr_nxt   = CNT_W'(STAB_CYCLES - 1);
				end
			end
			ST_EXIT: begin
				if (tmr_done) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= ST_IDLE;
			tmr_r   <= '0;
		end else begin
			state_r <= state_nxt;
			tmr_r   <= tmr_nxt;
		end
	end

	// Operation latched at start so limits cannot shift mid-run
	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			op_r <= FPS_OP_PGM;
		end else if (state_r == ST_IDLE && start) begin
			op_r <= op;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pcnt_r <= '0;
		end else if (state_r == ST_IDLE && start) begin
			pcnt_r <= '0;
		end else if (state_r == ST_SETUP && tmr_done) begin
			pcnt_r <= pcnt_r + PCNT_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			mode_r <= MODE_IDLE;
		end else begin
			mode_r        <= MODE_IDLE;
			mode_r.pgm    <= (op_sel == FPS_OP_PGM) &&
			                 (state_nxt == ST_SETUP || state_nxt == ST_PULSE);
			mode_r.erase  <= (op_sel == FPS_OP_ERASE) &&
			                 (state_nxt == ST_SETUP || state_nxt == ST_PULSE);
			mode_r.flw    <= (op_sel == FPS_OP_FLW) &&
			                 (state_nxt == ST_SETUP || state_nxt == ST_PULSE);
			mode_r.pulse  <= (state_nxt == ST_PULSE);
			mode_r.verify <= (state_nxt == ST_VSETUP || state_nxt == ST_VCHECK);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			busy_r   <= 1'b0;
			done_r   <= 1'b0;
			result_r <= '0;
		end else begin
			busy_r <= (state_nxt != ST_IDLE);
			done_r <= (state_r == ST_EXIT) && tmr_done;
			if (state_r == ST_IDLE && start) begin
				result_r <= '0;
			end else if (pass_nxt || fail_nxt) begin
				result_r.pass   <= pass_nxt;
				result_r.fail   <= fail_nxt;
				result_r.pulses <= pcnt_r;
			end
		end
	end

endmodule

// ===== src/fps_pkg.sv
// Package: modes, timing constants and status codes of the flash pulse sequencer
package fps_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ           = 100;
	localparam int T_STAB_US         = 10;
	localparam int T_PGM_NOM_US      = 100;
	localparam int T_ERASE_NOM_US    = 7000;
	localparam int T_FLW_NOM_US      = 14000;
	localparam int STAB_CYC          = T_STAB_US * CLK_MHZ;
	localparam int PGM_CYC           = T_PGM_NOM_US * CLK_MHZ;
	localparam int ERASE_CYC         = T_ERASE_NOM_US * CLK_MHZ;
	localparam int FLW_CYC           = T_FLW_NOM_US * CLK_MHZ;

	// ------------------------------------------------------------
	// Pulse count limits
	// ------------------------------------------------------------
	localparam int PGM_MAX_PULSES    = 150;
	localparam int ERASE_MAX_PULSES  = 1000;
	localparam int FLW_MAX_PULSES    = 6000;

	localparam int CNT_W             = 24;
	localparam int PCNT_W            = 13;

	// ------------------------------------------------------------
	// Operation kinds and array modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FPS_OP_PGM   = 2'h0,
		FPS_OP_ERASE = 2'h1,
		FPS_OP_FLW   = 2'h2
	} fps_op_t;

	typedef struct packed {
		logic pgm;
		logic erase;
		logic flw;
		logic verify;
		logic pulse;
	} fps_mode_t;

	localparam fps_mode_t MODE_IDLE = '0;

	typedef struct packed {
		logic              pass;
		logic              fail;
		logic [PCNT_W-1:0] pulses;
	} fps_result_t;

endpackage

// ===== bench/fps_seq_monitor.sv
// Checker: mode timing and pulse-count assertions on the sequencer ports
module fps_seq_monitor
	import fps_pkg::*;
#(
	parameter int STAB_CYCLES  = STAB_CYC,
	parameter int PGM_CYCLES   = PGM_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int FLW_CYCLES   = FLW_CYC
) (
	// Clock and command
	input wire logic        ref_clk,
	input wire logic        rstn,
	input wire logic        start,
	input wire fps_op_t     op,
	// Array and status
	input wire fps_mode_t   mode_r,
	input wire logic        busy_r,
	input wire logic        done_r,
	input wire fps_result_t result_r
);
	timeunit 1ns;
	timeprecision 1ps;
	fps_op_t           ol_r;
	logic [CNT_W-1:0]  pc_r, sc_r, ic_r, vc_r;
	logic [PCNT_W-1:0] np_r;
	logic              sel, sel_ok;
	int                len, mx;
	assign sel = mode_r.pgm | mode_r.erase | mode_r.flw;
	assign len = ol_r == FPS_OP_PGM ? PGM_CYCLES : ol_r == FPS_OP_ERASE ? ERASE_CYCLES : FLW_CYCLES;
	assign mx = ol_r == FPS_OP_PGM ? PGM_MAX_PULSES :
		ol_r == FPS_OP_ERASE ? ERASE_MAX_PULSES : FLW_MAX_PULSES;
	assign sel_ok = {mode_r.pgm, mode_r.erase, mode_r.flw} ==
		{ol_r == FPS_OP_PGM, ol_r == FPS_OP_ERASE, ol_r == FPS_OP_FLW};
	// Setup count holds through the pulse in case the select stays up
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			{pc_r, sc_r, ic_r, vc_r, np_r} <= '0;
			ol_r <= FPS_OP_PGM;
		end else begin
			pc_r <= mode_r.pulse ? pc_r + 1'b1 : '0;
			sc_r <= !sel ? '0 : sc_r + CNT_W'(!mode_r.pulse);
			ic_r <= mode_r == MODE_IDLE ? ic_r + 1'b1 : '0;
			vc_r <= mode_r.verify ? vc_r + 1'b1 : '0;
			if (start && !busy_r) begin
				ol_r <= op;
				np_r <= '0;
			end else if (mode_r.pulse && pc_r == '0)
				np_r <= np_r + 1'b1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	pulse_len_a: assert property ($fell(mode_r.pulse) |-> pc_r == len)
		else $error("pulse length");
	sel_wait_a: assert property ($rose(mode_r.pulse) |-> sc_r >= STAB_CYCLES)
		else $error("select wait");
	desel_wait_a: assert property ($rose(mode_r.verify) |-> ic_r >= STAB_CYCLES)
		else $error("deselect wait");
	// Wait, one more cycle for the second sync stage, then the check cycle
	verify_wait_a: assert property ($fell(mode_r.verify) |-> vc_r >= STAB_CYCLES + 2)
		else $error("verify wait");
	sel_match_a: assert property (sel |-> sel_ok)
		else $error("select mismatch");
	pulse_max_a: assert property (mode_r.pulse |-> np_r <= mx)
		else $error("pulse count");
	fail_limit_a: assert property ($rose(result_r.fail) |-> result_r.pulses == mx)
		else $error("fail count");
	pass_count_a: assert property ($rose(result_r.pass) |-> result_r.pulses == np_r)
		else $error("pass count");
	done_state_a: assert property (done_r |-> ic_r >= STAB_CYCLES && (result_r.pass ^ result_r.fail))
		else $error("done state");
	cover property ($rose(result_r.pass));
	cover property ($rose(result_r.fail));
	cover property ($fell(mode_r.pulse) && ol_r == FPS_OP_FLW);
endmodule

bind fps_sequencer fps_seq_monitor #(.STAB_CYCLES(STAB_CYCLES), .PGM_CYCLES(PGM_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES), .FLW_CYCLES(FLW_CYCLES))
	fps_seq_monitor_inst (.ref_clk, .rstn, .start, .op, .mode_r, .busy_r, .done_r, .result_r);

// ===== bench/fps_array_model.sv
// Flash array model: counts applied pulses and answers verify reads
module fps_array_model
	import fps_pkg::*;
#(
	parameter int STAB_CYCLES = STAB_CYC
) (
	// Bench control
	input  wire logic      ref_clk,
	input  wire logic      clr,
	input  var  int        need,
	// Array pins
	input  wire fps_mode_t mode,
	output logic           verify_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	int   cnt = 0;
	int   vh  = 0;
	logic last_r = 1'b0;
	logic tog_r  = 1'b0;
	always_ff @(posedge ref_clk) begin
		last_r <= mode.pulse;
		tog_r  <= !tog_r;
		vh     <= mode.verify ? vh + 1 : 0;
		if (clr)
			cnt <= 0;
		else if (mode.pulse && !last_r)
			cnt <= cnt + 1;
	end
	// Toggles outside a settled verify so an early or stray sample is caught
	assign verify_ok = (mode.verify && vh >= STAB_CYCLES - 1) ? (cnt >= need) : tog_r;
endmodule

// ===== bench/tb.sv
// Testbench: runs each operation against the array model and a count model
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fps_pkg::*;
	localparam int MX[3] = '{PGM_MAX_PULSES, ERASE_MAX_PULSES, FLW_MAX_PULSES};
	logic        ref_clk = 1'b0, rstn = 1'b0, start = 1'b0, clr = 1'b0, verify_ok, busy_r, done_r;
	fps_op_t     op = FPS_OP_PGM;
	fps_mode_t   mode_r;
	fps_result_t result_r;
	int          need = 1, bad_count = 0, checked = 0, cyc = 0;
	always #5 ref_clk = !ref_clk;
	fps_sequencer #(.STAB_CYCLES(4), .PGM_CYCLES(8), .ERASE_CYCLES(12), .FLW_CYCLES(16))
		fps_sequencer_inst (.ref_clk, .rstn, .start, .op, .verify_ok, .mode_r, .busy_r,
		.done_r, .result_r);
	fps_array_model #(.STAB_CYCLES(4)) fps_array_model_inst (.ref_clk, .clr, .need,
		.mode(mode_r), .verify_ok);
	task automatic stop_test();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(logic ok);
		checked++;
		if (!ok) begin
			bad_count++;
			$display("Error at %0t: mismatch", $time);
		end
	endtask
	// Second start while busy carries a random op; it must be ignored
	task automatic run(fps_op_t o, int n);
		fps_result_t e;
		int          w;
		e.pass = n <= MX[o];
		e.fail = !e.pass;
		e.pulses = PCNT_W'(e.pass ? n : MX[o]);
		@(negedge ref_clk);
		need = n;
		op = o;
		clr = 1'b1;
		start = 1'b1;
		@(negedge ref_clk);
		clr = 1'b0;
		start = 1'b0;
		check(busy_r === 1'b1);
		repeat (3) @(negedge ref_clk);
		op = fps_op_t'($urandom_range(2));
		start = 1'b1;
		@(negedge ref_clk);
		start = 1'b0;
		w = 0;
		while (done_r !== 1'b1 && w < 9000) begin
			@(negedge ref_clk);
			w++;
		end
		check(done_r === 1'b1 && result_r === e);
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			stop_test();
		end
	end
	initial begin
		void'($urandom(86));
		repeat (3) @(negedge ref_clk);
		rstn = 1'b1;
		repeat (4) @(negedge ref_clk);
		for (int i = 0; i < 6; i++)
			run(fps_op_t'(i % 3), $urandom_range(1, 5));
		run(FPS_OP_PGM, 200);
		stop_test();
	end
endmodule
